// ==== design/scc_changeover.sv ====
`timescale 1ns/1ns
// Overview of operation
// - One common selection drives every channel at once
// - Remote auto-disable low suppresses automatic switching
// - Remote toggle low pulse acts like the local select button
// - Local button and remote toggle ANDed, active low, into one command
// - Primary and backup active indicators, active high, follow selection
// - Alarm latched high on any bad input until cleared and reset
// - Remote fault reset acts like local reset, only once fault is gone
// - Fault contact closes on power loss, and latched on bad input
// - Checked channel without valid signal is reported faulty
// - Auto, no command: go to sole good input, else hold
// - Manual, no command: hold selection whatever the status
// - Command: sole good input, else toggle, except override manual
// - Override manual: command toggles unconditionally
// - Power absent: output path on primary
// - After power-up: primary, auto on, faults clear, panel locked
// - Detection disabled for selector position times thirty seconds
// - Panel locks after one idle minute, only unlock stays usable
module scc_changeover #(
	parameter int NCH = scc_pkg::NCH_DEF,
	parameter logic [31:0] STEP_CYCLES = scc_pkg::STEP_CYC,
	parameter logic [33:0] LOCK_CYCLES = scc_pkg::LOCK_CYC
) (
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	input wire logic POWER_OK_IN,
	input wire logic SEL_BTN_N_IN,
	input wire logic RST_BTN_N_IN,
	input wire logic AUTO_BTN_N_IN,
	input wire logic UNLOCK_BTN_N_IN,
	input wire logic REM_TOGGLE_N_IN,
	input wire logic REM_AUTO_N_IN,
	input wire logic REM_RESET_N_IN,
	input wire logic [3:0] DELAY_SEL_IN,
	input wire logic [NCH-1:0] PRI_GOOD_IN,
	input wire logic [NCH-1:0] BAK_GOOD_IN,
	output logic [NCH-1:0] CHAN_SEL_OUT,
	output logic PRI_ACTIVE_OUT,
	output logic BAK_ACTIVE_OUT,
	output logic ALARM_OUT,
	output logic FAULT_CLOSE_OUT,
	output logic PRI_FAULT_LED_OUT,
	output logic BAK_FAULT_LED_OUT,
	output logic AUTO_LED_OUT,
	output logic PANEL_EN_OUT,
	output logic ARMED_OUT
);
	localparam int SW = scc_pkg::SY_GOOD + 2 * NCH;

	if (NCH < 1 || NCH > 16 || STEP_CYCLES == 32'h0 || LOCK_CYCLES == 34'h0)
	begin : g_chk
		$error("scc_changeover parameters out of range");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	scc_pin_if #(.W(SW)) pin ();

	scc_sync #(.W(SW)) u_sync (
		.clk_in(CLK_IN),
		.nrst_in(NRST_IN),
		.raw_in({BAK_GOOD_IN, PRI_GOOD_IN, DELAY_SEL_IN, REM_RESET_N_IN, REM_AUTO_N_IN,
			REM_TOGGLE_N_IN, UNLOCK_BTN_N_IN, AUTO_BTN_N_IN, RST_BTN_N_IN, SEL_BTN_N_IN, POWER_OK_IN}),
		.pins(pin.src)
	);

	// ****************************************
	// State
	// ****************************************
	scc_pkg::scc_phase_t phase_reg;
	scc_pkg::scc_phase_t phase_next;
	logic [31:0] step_cnt_reg;
	logic [3:0] pos_reg;
	logic [33:0] idle_cnt_reg;
	logic panel_en_reg;
	logic auto_reg;
	logic ovr_reg;
	logic [NCH-1:0] chk_en_reg;
	logic cmd_prev_reg;
	logic sel_reg;
	logic sel_next;
	logic fpri_reg;
	logic fpri_next;
	logic fbak_reg;
	logic fbak_next;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic hresp_reg;
	logic hready_reg;
	logic [NCH-1:0] chan_sel_reg;
	logic pri_act_reg;
	logic alarm_reg;
	logic fclose_reg;

	// ****************************************
	// Decode
	// ****************************************
	wire logic pwr = pin.lvl[scc_pkg::SY_PWR];
	wire logic armed = (phase_reg == scc_pkg::SCC_PH_ARMED);
	wire logic loc_ok = panel_en_reg & armed;
	wire logic [3:0] dly_pos = pin.lvl[scc_pkg::SY_DLY +: 4];
	wire logic [NCH-1:0] pri_good = pin.lvl[scc_pkg::SY_GOOD +: NCH];
	wire logic [NCH-1:0] bak_good = pin.lvl[scc_pkg::SY_GOOD + NCH +: NCH];
	wire logic pri_bad = armed & (|(chk_en_reg & ~pri_good));
	wire logic bak_bad = armed & (|(chk_en_reg & ~bak_good));
	wire logic p_ok = ~pri_bad;
	wire logic b_ok = ~bak_bad;
	wire logic cmd_lvl_n = (pin.lvl[scc_pkg::SY_SEL] | ~loc_ok) & pin.lvl[scc_pkg::SY_RTOG];
	wire logic cmd = cmd_prev_reg & ~cmd_lvl_n;
	wire logic rst_cmd = pin.fall[scc_pkg::SY_RRST] | (loc_ok & pin.fall[scc_pkg::SY_RST]);
	wire logic auto_tgl = loc_ok & pin.fall[scc_pkg::SY_AUTO];
	wire logic unlock = armed & pin.fall[scc_pkg::SY_UNLK];
	wire logic activity = loc_ok & (pin.fall[scc_pkg::SY_SEL] | pin.fall[scc_pkg::SY_RST] | auto_tgl);
	wire logic auto_eff = auto_reg & pin.lvl[scc_pkg::SY_RAUTO] & armed;
	wire logic one_good = p_ok ^ b_ok;
	wire logic ahb_go = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
	wire logic wr_ctrl = wr_pend_reg & (wr_addr_reg == scc_pkg::OFF_CTRL);
	wire logic wr_chk = wr_pend_reg & (wr_addr_reg == scc_pkg::OFF_CHK);
	wire logic [31:0] stat_word = {20'h0, pos_reg, pwr, auto_eff, armed, panel_en_reg,
		alarm_reg, fbak_reg, fpri_reg, sel_reg};
	wire logic [31:0] rd_mux =
		(HADDR_IN[7:0] == scc_pkg::OFF_CTRL) ? {30'h0, ovr_reg, auto_reg} :
		(HADDR_IN[7:0] == scc_pkg::OFF_CHK) ? 32'(chk_en_reg) :
		(HADDR_IN[7:0] == scc_pkg::OFF_STAT) ? stat_word : 32'h0;

	// ****************************************
	// Source selection
	// ****************************************
	always_comb
	begin
		sel_next = sel_reg;
		if (!pwr)
			sel_next = 1'b0;
		else if (cmd && ovr_reg && !auto_eff)
			sel_next = ~sel_reg;
		else if (cmd)
			sel_next = one_good ? b_ok : ~sel_reg;
		else if (auto_eff && one_good)
			sel_next = b_ok;
	end

	// ****************************************
	// Fault latches
	// ****************************************
	// set wins over reset
	// reset clears only a gone fault
	assign fpri_next = pri_bad | (fpri_reg & ~rst_cmd);
	assign fbak_next = bak_bad | (fbak_reg & ~rst_cmd);

	// ****************************************
	// Power-on delay
	// ****************************************
	always_comb
	begin
		case (phase_reg)
			scc_pkg::SCC_PH_DELAY: phase_next = (pos_reg == dly_pos) ? scc_pkg::SCC_PH_ARMED : phase_reg;
			scc_pkg::SCC_PH_ARMED: phase_next = phase_reg;
			default: phase_next = scc_pkg::SCC_PH_DELAY;
		endcase
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!NRST_IN)
		begin
			phase_reg <= scc_pkg::SCC_PH_DELAY;
			step_cnt_reg <= 32'h0;
			pos_reg <= 4'h0;
		end
		else
		begin
			phase_reg <= phase_next;
			if (!armed && pos_reg != dly_pos)
			begin
				step_cnt_reg <= (step_cnt_reg == STEP_CYCLES - 32'h1) ? 32'h0 : step_cnt_reg + 32'h1;
				pos_reg <= (step_cnt_reg == STEP_CYCLES - 32'h1) ? pos_reg + 4'h1 : pos_reg;
			end
		end
	end

	// ****************************************
	// Panel lockout
	// ****************************************
	// idle minute locks panel
	always_ff @(posedge CLK_IN)
	begin
		if (!NRST_IN)
		begin
			panel_en_reg <= 1'b0;
			idle_cnt_reg <= 34'h0;
		end
		else if (unlock || activity || !panel_en_reg)
		begin
			panel_en_reg <= panel_en_reg ^ unlock;
			idle_cnt_reg <= 34'h0;
		end
		else if (idle_cnt_reg == LOCK_CYCLES - 34'h1)
		begin
			panel_en_reg <= 1'b0;
			idle_cnt_reg <= 34'h0;
		end
		else
			idle_cnt_reg <= idle_cnt_reg + 34'h1;
	end

	// ****************************************
	// Control state and outputs
	// ****************************************
	// power-up defaults
	always_ff @(posedge CLK_IN)
	begin
		if (!NRST_IN)
		begin
			auto_reg <= scc_pkg::CTRL_AUTO_RST;
			ovr_reg <= scc_pkg::CTRL_OVR_RST;
			chk_en_reg <= scc_pkg::CHK_RST[NCH-1:0];
			cmd_prev_reg <= 1'b1;
			sel_reg <= 1'b0;
			fpri_reg <= 1'b0;
			fbak_reg <= 1'b0;
			chan_sel_reg <= '0;
			pri_act_reg <= 1'b1;
			alarm_reg <= 1'b0;
			fclose_reg <= 1'b0;
		end
		else
		begin
			// Software write lands after a panel toggle in the same cycle
			auto_reg <= wr_ctrl ? HWDATA_IN[scc_pkg::CTRL_AUTO] : auto_reg ^ auto_tgl;
			ovr_reg <= wr_ctrl ? HWDATA_IN[scc_pkg::CTRL_OVR] : ovr_reg;
			chk_en_reg <= wr_chk ? HWDATA_IN[NCH-1:0] : chk_en_reg;
			cmd_prev_reg <= cmd_lvl_n;
			sel_reg <= sel_next;
			fpri_reg <= fpri_next;
			fbak_reg <= fbak_next;
			chan_sel_reg <= {NCH{sel_next}};
			pri_act_reg <= ~sel_next;
			alarm_reg <= fpri_next | fbak_next;
			// contact closed on power loss or fault
			fclose_reg <= ~pwr | fpri_next | fbak_next;
		end
	end

	// ****************************************
	// Bus slave
	// ****************************************
	// Zero wait states; reads sample state at the address phase
	always_ff @(posedge CLK_IN)
	begin
		if (!NRST_IN)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h0;
			hrdata_reg <= 32'h0;
			hresp_reg <= 1'b0;
			hready_reg <= 1'b1;
		end
		else
		begin
			wr_pend_reg <= ahb_go & HWRITE_IN;
			wr_addr_reg <= HADDR_IN[7:0];
			hrdata_reg <= (ahb_go && !HWRITE_IN) ? rd_mux : 32'h0;
			hresp_reg <= 1'b0;
			hready_reg <= 1'b1;
		end
	end

	assign HRDATA_OUT = hrdata_reg;
	assign HREADYOUT_OUT = hready_reg;
	assign HRESP_OUT = hresp_reg;
	assign CHAN_SEL_OUT = chan_sel_reg;
	assign PRI_ACTIVE_OUT = pri_act_reg;
	assign BAK_ACTIVE_OUT = sel_reg;
	assign ALARM_OUT = alarm_reg;
	assign FAULT_CLOSE_OUT = fclose_reg;
	assign PRI_FAULT_LED_OUT = fpri_reg;
	assign BAK_FAULT_LED_OUT = fbak_reg;
	assign AUTO_LED_OUT = auto_reg;
	assign PANEL_EN_OUT = panel_en_reg;
	assign ARMED_OUT = armed;

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);

	chk_common_sel: assert property (CHAN_SEL_OUT == {NCH{BAK_ACTIVE_OUT}})
		else $error("channels disagree");
	chk_remote_auto: assert property (!pin.lvl[scc_pkg::SY_RAUTO] && !cmd && pwr |=> $stable(sel_reg))
		else $error("switched while remote disabled");
	chk_cmd_single: assert property (cmd |=> !cmd)
		else $error("command longer than one cycle");
	chk_indicator_pair: assert property (PRI_ACTIVE_OUT != BAK_ACTIVE_OUT)
		else $error("indicators not exclusive");
	chk_alarm_latched: assert property (ALARM_OUT && !rst_cmd |=> ALARM_OUT)
		else $error("alarm dropped without reset");
	chk_reset_blocked: assert property (rst_cmd && pri_bad |=> PRI_FAULT_LED_OUT)
		else $error("reset cleared a live fault");
	chk_power_contact: assert property (!pwr |=> FAULT_CLOSE_OUT && !BAK_ACTIVE_OUT)
		else $error("power loss not handled");
	chk_power_primary: assert property (!pwr |=> PRI_ACTIVE_OUT)
		else $error("no power but not primary");
	chk_override_toggle: assert property (cmd && pwr && ovr_reg && !auto_eff |=> sel_reg != $past(sel_reg))
		else $error("override command did not toggle");
	chk_manual_hold: assert property (!cmd && pwr && !auto_eff |=> $stable(sel_reg))
		else $error("manual selection moved");
	chk_auto_follow: assert property (!cmd && pwr && auto_eff && pri_bad && !bak_bad |=> sel_reg)
		else $error("auto did not go to backup");
	chk_bad_channel: assert property (pri_bad |=> ALARM_OUT && PRI_FAULT_LED_OUT)
		else $error("bad channel not reported");
	chk_power_up: assert property ($rose(NRST_IN) |-> PRI_ACTIVE_OUT && !PANEL_EN_OUT && !ALARM_OUT)
		else $error("power-up state wrong");

	cov_cmd_backup: cover property (cmd ##1 sel_reg);
	cov_auto_switch: cover property (auto_eff && pri_bad ##1 sel_reg);
	cov_lockout: cover property (panel_en_reg ##1 !panel_en_reg);
endmodule

// ==== design/scc_pkg.sv ====
package scc_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam longint unsigned CLK_HZ = 100_000_000;
	localparam longint unsigned STEP_S = 30;
	localparam longint unsigned LOCK_S = 60;
	localparam logic [31:0] STEP_CYC = 32'(STEP_S * CLK_HZ);
	localparam logic [33:0] LOCK_CYC = 34'(LOCK_S * CLK_HZ);
	localparam int NCH_DEF = 11;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CHK = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam int CTRL_AUTO = 0;
	localparam int CTRL_OVR = 1;
	localparam logic CTRL_AUTO_RST = 1'h1;
	localparam logic CTRL_OVR_RST = 1'h0;
	localparam logic [15:0] CHK_RST = 16'h07ff;
	localparam int ST_BAK = 0;
	localparam int ST_FPRI = 1;
	localparam int ST_FBAK = 2;
	localparam int ST_ALARM = 3;
	localparam int ST_PANEL = 4;
	localparam int ST_ARMED = 5;
	localparam int ST_AUTO = 6;
	localparam int ST_PWR = 7;
	localparam int ST_POS = 8;

	// ****************************************
	// Synchroniser lanes
	// ****************************************
	localparam int SY_PWR = 0;
	localparam int SY_SEL = 1;
	localparam int SY_RST = 2;
	localparam int SY_AUTO = 3;
	localparam int SY_UNLK = 4;
	localparam int SY_RTOG = 5;
	localparam int SY_RAUTO = 6;
	localparam int SY_RRST = 7;
	localparam int SY_DLY = 8;
	localparam int SY_GOOD = 12;

	typedef enum logic [0:0] {
		SCC_PH_DELAY = 1'h0,
		SCC_PH_ARMED = 1'h1
	} scc_phase_t;

endpackage

// ==== design/scc_pin_if.sv ====
`timescale 1ns/1ns
interface scc_pin_if #(
	parameter int W = 8
);
	logic [W-1:0] lvl;
	logic [W-1:0] fall;
	modport src (output lvl, output fall);
	modport snk (input lvl, input fall);
endinterface

// ==== design/scc_sync.sv ====
`timescale 1ns/1ns
module scc_sync #(
	parameter int W = 8
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [W-1:0] raw_in,
	scc_pin_if.src pins
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	if (W < 1)
	begin : g_chk
		$error("scc_sync width must be positive");
	end

	// ****************************************
	// Two-stage capture, then edge
	// ****************************************
	// Idle level is high so no false fall after reset
	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
		end
		else
		begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign pins.lvl = s2_reg;
	assign pins.fall = s3_reg & ~s2_reg;
endmodule

// ==== tb/scc_remote_model.sv ====
`timescale 1ns/1ns
// ****************************************
// Remote contact panel
// ****************************************
module scc_remote_model (
	input wire logic clk_in,
	output logic tog_n_out,
	output logic auto_n_out,
	output logic rst_n_out
);
	initial
	begin
		tog_n_out = 1'b1;
		auto_n_out = 1'b1;
		rst_n_out = 1'b1;
	end

	task automatic toggle();
		@(posedge clk_in);
		tog_n_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		tog_n_out <= 1'b1;
	endtask

	task automatic fault_reset();
		@(posedge clk_in);
		rst_n_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_out <= 1'b1;
	endtask

	task automatic set_auto(input logic v);
		@(posedge clk_in);
		auto_n_out <= v;
	endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
	localparam int NCH = 11;
	logic clk, nrst, hwrite, hrdy, hresp, pwr;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [NCH-1:0] pg, bg, chan;
	logic pa, ba, alarm, fclose, pfl, bfl, aled, pen, armed, tog_n, rauto_n, rrst_n;
	logic [3:0] btn_n;
	logic sel, au, ov, ra, pf, bf;
	logic [10:0] chk;
	int err_count, total_checks, n, i, j;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Short counts keep the run small
	scc_changeover #(.NCH(NCH), .STEP_CYCLES(32'h14), .LOCK_CYCLES(34'h32)) dut (
		.CLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
		.HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hrdy),
		.HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp), .POWER_OK_IN(pwr),
		.SEL_BTN_N_IN(btn_n[0]), .RST_BTN_N_IN(btn_n[1]), .AUTO_BTN_N_IN(btn_n[2]),
		.UNLOCK_BTN_N_IN(btn_n[3]), .REM_TOGGLE_N_IN(tog_n), .REM_AUTO_N_IN(rauto_n),
		.REM_RESET_N_IN(rrst_n), .DELAY_SEL_IN(4'h1), .PRI_GOOD_IN(pg), .BAK_GOOD_IN(bg),
		.CHAN_SEL_OUT(chan), .PRI_ACTIVE_OUT(pa), .BAK_ACTIVE_OUT(ba), .ALARM_OUT(alarm),
		.FAULT_CLOSE_OUT(fclose), .PRI_FAULT_LED_OUT(pfl), .BAK_FAULT_LED_OUT(bfl),
		.AUTO_LED_OUT(aled), .PANEL_EN_OUT(pen), .ARMED_OUT(armed));

	scc_remote_model rem (.clk_in(clk), .tog_n_out(tog_n), .auto_n_out(rauto_n), .rst_n_out(rrst_n));

	// ****************************************
	// Reference model
	// ****************************************
	function automatic logic nxt(logic s, logic cmd, logic a, logic o, logic p, logic b);
		if (cmd && o && !a)
			return ~s;
		if ((cmd || a) && p != b)
			return b;
		if (cmd)
			return ~s;
		return s;
	endfunction

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// ****************************************
	// Bus and pin drivers
	// ****************************************
	task automatic wait_rdy();
		int k;
		k = 0;
		@(posedge clk);
		while (hrdy !== 1'b1 && k < 20)
		begin
			k++;
			@(posedge clk);
		end
		if (hrdy !== 1'b1)
		begin
			err_count++;
			stop_test();
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= 32'(a);
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		r = hrdata;
		check(32'(hresp), 32'h0);
	endtask

	// Trailing idle edge keeps two pulses apart
	task automatic press(input logic [3:0] m);
		btn_n <= ~m;
		repeat (3) @(posedge clk);
		btn_n <= 4'hf;
		@(posedge clk);
	endtask

	task automatic settle(input logic cmd, input logic rst);
		logic p, b;
		repeat (8) @(posedge clk);
		p = &(pg | ~chk);
		b = &(bg | ~chk);
		sel = nxt(sel, cmd, au & ra, ov, p, b);
		pf = rst ? ~p : pf | ~p;
		bf = rst ? ~b : bf | ~b;
		check(32'(chan), sel ? 32'h7ff : 32'h0);
		check(32'({pa, ba}), 32'({~sel, sel}));
		check(32'({alarm, fclose, pfl, bfl}), 32'({pf | bf, pf | bf, pf, bf}));
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		nrst = 1'b0;
		pwr = 1'b1;
		btn_n = 4'hf;
		pg = 11'h7ff;
		bg = 11'h7ff;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		{sel, ov, pf, bf} = 4'h0;
		{au, ra} = 2'h3;
		chk = 11'h7ff;
		err_count = 0;
		total_checks = 0;
		void'($urandom(68));
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		check(32'({pa, ba, alarm, fclose, pen, armed, aled}), 32'h41);
		for (n = 0; n < 200 && armed !== 1'b1; n++)
			@(posedge clk);
		check(32'(n >= 15 && n <= 30), 32'h1);
		ahb(1'b0, scc_pkg::OFF_CTRL, 32'h0, rd);
		check(rd, 32'h1);
		ahb(1'b0, 8'h0c, 32'h0, rd);
		check(rd, 32'h0);
		press(4'h8);
		settle(1'b0, 1'b0);
		check(32'(pen), 32'h1);
		fork
			press(4'h1);
			rem.toggle();
		join
		settle(1'b1, 1'b0);
		press(4'h4);
		au = 1'b0;
		settle(1'b0, 1'b0);
		check(32'(aled), 32'h0);
		press(4'h4);
		au = 1'b1;
		settle(1'b0, 1'b0);
		check(32'(aled), 32'h1);
		repeat (60) @(posedge clk);
		check(32'(pen), 32'h0);
		press(4'h1);
		settle(1'b0, 1'b0);
		for (int t = 0; t < 40; t++)
		begin
			ra = 1'($urandom);
			rem.set_auto(ra);
			settle(1'b0, 1'b0);
			au = 1'($urandom);
			ov = 1'($urandom);
			ahb(1'b1, scc_pkg::OFF_CTRL, {30'h0, ov, au}, rd);
			settle(1'b0, 1'b0);
			check(32'(aled), 32'(au));
			i = $urandom % NCH;
			j = $urandom % NCH;
			chk = ($urandom % 4 == 0) ? ~(11'h1 << i) : 11'h7ff;
			ahb(1'b1, scc_pkg::OFF_CHK, 32'(chk), rd);
			ahb(1'b0, scc_pkg::OFF_CHK, 32'h0, rd);
			check(rd, 32'(chk));
			settle(1'b0, 1'b0);
			pg <= ($urandom % 2) ? ~(11'h1 << i) : 11'h7ff;
			bg <= ($urandom % 2) ? ~(11'h1 << j) : 11'h7ff;
			settle(1'b0, 1'b0);
			if ($urandom % 2)
			begin
				rem.fault_reset();
				settle(1'b0, 1'b1);
			end
			else
			begin
				press(4'h2);
				settle(1'b0, 1'b0);
			end
			if ($urandom % 2)
			begin
				rem.toggle();
				settle(1'b1, 1'b0);
			end
			ahb(1'b0, scc_pkg::OFF_STAT, 32'h0, rd);
			check(32'(rd[6:0]), 32'({au & ra, 2'h2, pf | bf, bf, pf, sel}));
		end
		pwr <= 1'b0;
		repeat (8) @(posedge clk);
		check(32'({chan[0], pa, fclose}), 32'h3);
		stop_test();
	end
endmodule
